// ===== bench/pte_partner.sv
`timescale 1ns/1ns
// Far side stand-in: request counter and external event source
module pte_partner (
    input wire logic ref_clk_i, // Peripheral clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic irq_i, // Shared timer request
    input wire logic [7:0] burst_i, // Pulses to send, taken while idle
    output logic ext_clk_o, // External count clock pin
    output logic busy_o, // Burst in progress
    output logic [7:0] irq_count_o // Request rises seen
);
    logic irq_q;
    logic [7:0] left_q;
    logic [3:0] ph_q;

    // One line carries both causes, so only rises are counted
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
            irq_count_o <= 8'h00;
        end else begin
            irq_q <= irq_i;
            irq_count_o <= irq_count_o + 8'(irq_i & !irq_q);
        end
    end

    // Pin only ever driven into the block, low between bursts
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left_q <= 8'h00;
            ph_q <= 4'h0;
            ext_clk_o <= 1'b0;
        end else if (left_q == 8'h00) begin
            left_q <= burst_i;
            ph_q <= 4'h0;
            ext_clk_o <= 1'b0;
        end else begin
            ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
            ext_clk_o <= (ph_q < 4'h5);
            if (ph_q == 4'h9) left_q <= left_q - 8'h01;
        end
    end
    assign busy_o = (left_q != 8'h00);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import pte_pkg::*;
    typedef struct packed {logic [15:0] v; logic [15:0] m;} pte_exp_type;
    logic ref_clk_i;
    logic resetn_i;
    logic [15:0] bus_addr;
    logic bus_rd;
    logic bus_wr;
    logic [31:0] bus_wdata;
    logic [31:0] bus_rdata;
    logic bus_wait;
    logic ext_clk;
    logic wave_p;
    logic wave_n;
    logic irq;
    logic [7:0] burst;
    logic busy;
    logic [7:0] irq_cnt;
    int fail_count;
    int checked;
    pte_exp_type exp_q[$];
    pte_exp_type e_w;
    logic [15:0] rv;
    logic [15:0] c1;
    logic [15:0] regs[7] = '{PTE_IDX_CMP_A, PTE_IDX_CMP_B, PTE_IDX_COUNT, PTE_IDX_CTL,
        PTE_IDX_DIV, PTE_IDX_IRQ_EN, PTE_IDX_FLAGS};
    logic [15:0] row_ctl[4] = '{16'h0000, 16'h0010, 16'h0040, 16'h0020};
    logic [15:0] row_a[4] = '{16'h0001, 16'h0001, 16'h0003, 16'h0001};
    logic [15:0] row_b[4] = '{16'h0007, 16'h0007, 16'h0007, 16'h0003};
    int row_ones[4] = '{48, 16, 40, 32};
    int ones;

    pte_top DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(bus_addr),
        .avs_read_i(bus_rd), .avs_write_i(bus_wr), .avs_writedata_i(bus_wdata),
        .avs_byteenable_i(4'h3), .avs_readdata_o(bus_rdata), .avs_waitrequest_o(bus_wait),
        .ext_count_clk_in_i(ext_clk), .wave_out_p_o(wave_p), .wave_out_n_o(wave_n),
        .irq_o(irq));
    pte_partner far_end (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .irq_i(irq),
        .burst_i(burst), .ext_clk_o(ext_clk), .busy_o(busy), .irq_count_o(irq_cnt));

    task automatic note_mismatch(input string msg);
        $display("mismatch at %0t: %s", $time, msg);
        fail_count++;
    endtask

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) note_mismatch(msg);
    endtask

    task automatic give_verdict;
        $display("counts: %0d checked, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Held until waitrequest is seen low; one idle edge keeps strobes apart
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
        input logic [15:0] m);
        int n;
        if (!w) exp_q.push_back({d, m});
        bus_addr <= a;
        bus_wdata <= {16'h0000, d};
        bus_wr <= w;
        bus_rd <= !w;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (bus_wait !== 1'b0 && n < 32);
        if (bus_wait !== 1'b0) begin
            note_mismatch("bus timeout");
            give_verdict();
        end
        rv = bus_rdata[15:0];
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        access(1'b1, a, d, 16'h0000);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] d);
        access(1'b0, a, d, 16'hFFFF);
    endtask

    task automatic endtest(input string s);
        $display("test %s done", s);
    endtask

    // Scoreboard: each completed read takes the oldest note
    always @(posedge ref_clk_i) begin
        if (bus_rd === 1'b1 && bus_wait === 1'b0) begin
            e_w = exp_q.pop_front();
            checked++;
            if ((((bus_rdata[15:0] ^ e_w.v) & e_w.m) !== 16'h0000) ||
                (bus_rdata[31:16] !== 16'h0000))
                note_mismatch($sformatf("read %h expected %h", bus_rdata, e_w.v));
        end
    end

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        resetn_i = 1'b0;
        bus_addr = 16'h0000;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = 32'h0000_0000;
        burst = 8'h00;
        fail_count = 0;
        checked = 0;
        void'($urandom(32'h9669E828));
        repeat (10) @(posedge ref_clk_i);
        check(wave_p === 1'b0 && wave_n === 1'b1 && irq === 1'b0, "reset pins");
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        // Reset values and map, an unmapped index reads zero
        foreach (regs[k]) rd(regs[k], 16'h0000);
        rd(16'h5310, 16'h0000);
        c1 = 16'($urandom);
        wr(PTE_IDX_CMP_A, c1);
        rd(PTE_IDX_CMP_A, c1);
        c1 = 16'($urandom);
        wr(PTE_IDX_CMP_B, c1);
        rd(PTE_IDX_CMP_B, c1);
        wr(PTE_IDX_CTL, 16'h017F);
        rd(PTE_IDX_CTL, 16'h017D);
        wr(PTE_IDX_CTL, 16'h0000);
        wr(PTE_IDX_DIV, 16'h000E);
        rd(PTE_IDX_DIV, 16'h000E);
        wr(PTE_IDX_DIV, 16'h0000);
        endtest("registers");
        // Counter load, hold while stopped, count, clear with run
        wr(PTE_IDX_CMP_A, 16'hFFFF);
        wr(PTE_IDX_CMP_B, 16'hFFFF);
        wr(PTE_IDX_COUNT, 16'h1234);
        rd(PTE_IDX_COUNT, 16'h1234);
        repeat (20) @(posedge ref_clk_i);
        rd(PTE_IDX_COUNT, 16'h1234);
        wr(PTE_IDX_CTL, 16'h0003);
        rd(PTE_IDX_CTL, 16'h0001);
        wr(PTE_IDX_CTL, 16'h0000);
        access(1'b0, PTE_IDX_COUNT, 16'h0000, 16'h0000);
        check(rv != 16'h0000 && rv < 16'h0010, "clear then run");
        c1 = rv;
        repeat (20) @(posedge ref_clk_i);
        rd(PTE_IDX_COUNT, c1);
        // Divider codes: ticks across a 64-cycle gap
        for (int k = 0; k < 4; k++) begin
            wr(PTE_IDX_DIV, 16'(k));
            wr(PTE_IDX_COUNT, 16'h0000);
            wr(PTE_IDX_CTL, 16'h0001);
            access(1'b0, PTE_IDX_COUNT, 16'h0000, 16'h0000);
            c1 = rv;
            repeat (61) @(posedge ref_clk_i);
            access(1'b0, PTE_IDX_COUNT, 16'h0000, 16'h0000);
            check(16'(rv - c1) == 16'(64 >> k), "divider ticks");
            wr(PTE_IDX_CTL, 16'h0000);
        end
        wr(PTE_IDX_DIV, 16'h0000);
        endtest("counter");
        // External pin as count clock
        wr(PTE_IDX_COUNT, 16'h0000);
        wr(PTE_IDX_CTL, 16'h0009);
        burst <= 8'd5;
        @(posedge ref_clk_i);
        burst <= 8'd0;
        repeat (3) @(posedge ref_clk_i);
        for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge ref_clk_i);
        if (busy !== 1'b0) note_mismatch("burst timeout");
        if (busy !== 1'b0) give_verdict();
        repeat (10) @(posedge ref_clk_i);
        wr(PTE_IDX_CTL, 16'h0000);
        rd(PTE_IDX_COUNT, 16'd5);
        endtest("external clock");
        // Flags with enables off, then each enable pattern
        wr(PTE_IDX_CMP_A, 16'h0003);
        wr(PTE_IDX_CMP_B, 16'h0007);
        for (int en = 0; en < 4; en++) begin
            wr(PTE_IDX_FLAGS, 16'h0003);
            wr(PTE_IDX_IRQ_EN, 16'(en));
            c1 = {8'h00, irq_cnt};
            wr(PTE_IDX_CTL, 16'h0001);
            repeat (20) @(posedge ref_clk_i);
            wr(PTE_IDX_CTL, 16'h0000);
            rd(PTE_IDX_FLAGS, 16'(en));
            check(irq === (en != 0) && irq_cnt == 8'(c1) + 8'(en != 0), "irq line");
            wr(PTE_IDX_FLAGS, 16'h0000);
            rd(PTE_IDX_FLAGS, 16'(en));
            wr(PTE_IDX_FLAGS, 16'(en));
            rd(PTE_IDX_FLAGS, 16'h0000);
            check(irq === 1'b0, "irq dropped");
        end
        endtest("interrupts");
        // Duty per mode, complement checked every cycle
        for (int k = 0; k < 4; k++) begin
            wr(PTE_IDX_CTL, row_ctl[k]);
            wr(PTE_IDX_CMP_A, row_a[k]);
            wr(PTE_IDX_CMP_B, row_b[k]);
            wr(PTE_IDX_COUNT, 16'h0000);
            wr(PTE_IDX_CTL, row_ctl[k] | 16'h0005);
            repeat (24) @(posedge ref_clk_i);
            ones = 0;
            for (int j = 0; j < 64; j++) begin
                @(posedge ref_clk_i);
                ones += int'(wave_p);
                check(wave_n === ~wave_p, "complement");
            end
            check(ones == row_ones[k], "duty");
        end
        // Idle level with outputs disabled
        for (int k = 0; k < 4; k++) begin
            wr(PTE_IDX_CTL, {7'h00, k[0], 3'h0, k[1], 4'h0});
            repeat (2) @(posedge ref_clk_i);
            check(wave_p === (k[0] ^ k[1]) && wave_n === !(k[0] ^ k[1]), "idle");
        end
        endtest("outputs");
        give_verdict();
    end
endmodule

// ===== rtl/pte_cnt_if.sv
`timescale 1ns/1ns
interface pte_cnt_if;
    logic run;
    logic clk_sel;
    logic [3:0] div_code;
    logic tick;
    logic half;

    modport timer (output run, output clk_sel, output div_code, input tick, input half);
    modport clkgen (input run, input clk_sel, input div_code, output tick, output half);
endinterface

// ===== rtl/pte_count_clk.sv
`timescale 1ns/1ns
module pte_count_clk
    import pte_pkg::*;
(
    input wire logic ref_clk_i, // Peripheral clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic ext_count_clk_in_i, // External count clock pin
    pte_cnt_if.clkgen cnt // Count enables toward the timer
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic ext_lvl;
        logic [PTE_PRE_W-1:0] pre;
        logic tick;
        logic half;
    } pte_clk_state_type;

    pte_clk_state_type q, d;
    logic [3:0] div_eff;
    logic [PTE_PRE_W-1:0] mask;
    logic [PTE_PRE_W-1:0] phase;

    // Reserved divider code falls back to the slowest legal ratio
    assign div_eff = (cnt.div_code > PTE_DIV_MAX) ? PTE_DIV_MAX : cnt.div_code;
    assign mask = PTE_PRE_W'((15'h0001 << div_eff) - 15'h0001);
    assign phase = q.pre & mask;

    // Count enables: rising edge is tick, falling edge is half
    always_comb begin
        d = q;
        d.s1 = ext_count_clk_in_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Pin level only accepted once stages two and three agree
        if (q.s2 == q.s3) begin
            d.ext_lvl = q.s3;
        end
        d.tick = 1'b0;
        d.half = 1'b0;
        if (!cnt.run) begin
            d.pre = '0;
        end else if (cnt.clk_sel) begin
            d.tick = d.ext_lvl & ~q.ext_lvl;
            d.half = ~d.ext_lvl & q.ext_lvl;
        end else begin
            d.pre = q.pre + PTE_PRE_W'(1);
            d.tick = (phase == mask);
            // At 1/1 the falling edge is rounded to one peripheral clock later
            d.half = (div_eff == 4'h0) ? q.tick : (phase == (mask >> 1));
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt.tick = q.tick;
    assign cnt.half = q.half;

endmodule

// ===== rtl/pte_pkg.sv
package pte_pkg;

    // Register indices; Avalon word address equals the index (byte address is 4x)
    localparam logic [15:0] PTE_IDX_CMP_A = 16'h5300;
    localparam logic [15:0] PTE_IDX_CMP_B = 16'h5302;
    localparam logic [15:0] PTE_IDX_COUNT = 16'h5304;
    localparam logic [15:0] PTE_IDX_CTL = 16'h5306;
    localparam logic [15:0] PTE_IDX_DIV = 16'h5308;
    localparam logic [15:0] PTE_IDX_IRQ_EN = 16'h530A;
    localparam logic [15:0] PTE_IDX_FLAGS = 16'h530C;

    // Control register bit positions
    localparam int PTE_CTL_RUN_BIT = 0;
    localparam int PTE_CTL_CLR_BIT = 1;
    localparam int PTE_CTL_OUT_EN_BIT = 2;
    localparam int PTE_CTL_CLK_SEL_BIT = 3;
    localparam int PTE_CTL_INV_BIT = 4;
    localparam int PTE_CTL_BUF_EN_BIT = 5;
    localparam int PTE_CTL_FINE_BIT = 6;
    localparam int PTE_CTL_IDLE_BIT = 8;

    // Interrupt enable and flag bit positions
    localparam int PTE_IRQ_A_BIT = 0;
    localparam int PTE_IRQ_B_BIT = 1;

    // Reset values, and the largest legal divider code
    localparam logic [15:0] PTE_CMP_RESET = 16'h0000;
    localparam logic [15:0] PTE_COUNT_RESET = 16'h0000;
    localparam logic [3:0] PTE_DIV_RESET = 4'h0;
    localparam logic [3:0] PTE_DIV_MAX = 4'hE;
    localparam logic [1:0] PTE_IRQ_RESET = 2'h0;

    // Prescaler width covers the largest division, 2^14
    localparam int PTE_PRE_W = 14;

endpackage

// ===== rtl/pte_top.sv
// Function
// - One shared interrupt line carries both compare causes; flags show which.
// - Compare A match sets its flag only when compare A enable is set.
// - Compare B match sets its flag only when compare B enable is set.
// - Interrupt asserted while any flag is set together with its enable.
// - Writing 1 to a flag clears it; writing 0 does nothing.
// - Seven 16-bit registers at indices 0x5300 to 0x530C, step two.
// - Reserved bits read 0; software writes 0 into them.
// - Compare access goes direct, or via buffers loaded at counter reset.
// - Compare A match raises cause, drives output active, counter untouched.
// - Compare B match raises cause, drives output inactive, resets counter.
// - Counter register reads current count; a write loads it.
// - Idle level bit picks output level, inverted by polarity, used when disabled.
// - Fine mode bit gives half count clock duty steps.
// - Buffer enable loads compares on every counter reset, software or match.
// - Polarity bit inverts both outputs including idle level.
// - Count clock select picks divided peripheral clock or external pin.
// - Output enable drives waveform; cleared forces idle level.
// - Clear command bit is write-only, clears counter, reads 0.
// - Run bit counts when set; reset leaves timer stopped.
// - Stopping keeps the count so counting resumes from it.
// - Run and clear written together clear then start counting.
// - Fine mode matches A on bits 15:1; bit 0 picks edge.
// - Divider code n divides peripheral clock by 2^n, 0xF reserved.
`timescale 1ns/1ns
module pte_top
    import pte_pkg::*;
(
    input wire logic ref_clk_i, // Peripheral clock, 250 MHz
    input wire logic resetn_i, // Async reset, active low
    input wire logic [15:0] avs_address_i, // Word address (register index)
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [31:0] avs_writedata_i, // Write data, low half used
    input wire logic [3:0] avs_byteenable_i, // Byte lanes
    output logic [31:0] avs_readdata_o, // Read data, upper half zero
    output logic avs_waitrequest_o, // Stall until answer ready
    input wire logic ext_count_clk_in_i, // External count clock pin
    output logic wave_out_p_o, // Primary timer output
    output logic wave_out_n_o, // Complementary timer output
    output logic irq_o // Request to the irq_controller
);

    typedef struct packed {
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] count;
        logic idle_lvl;
        logic fine;
        logic buf_en;
        logic inv;
        logic clk_sel;
        logic out_en;
        logic run;
        logic [3:0] div;
        logic [1:0] irq_en;
        logic [1:0] flags;
        logic wave;
        logic pend_a;
        logic ack;
        logic [15:0] rdata;
        logic out_p;
        logic irq;
    } pte_top_state_type;

    pte_top_state_type q, d;
    pte_cnt_if cnt();

    logic req;
    logic wr;
    logic rd_acc;
    logic [15:0] wdata;
    logic [15:0] rd_mux;
    logic match_a;
    logic match_b;
    logic clr_cmd;
    logic cnt_wr;
    logic flag_wr;
    logic count_en;

    // Byte lane merge for the 16-bit data path
    function automatic logic [15:0] pte_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [3:0] be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (be[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // Count clock generation lives in its own module
    pte_count_clk u_clk (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .ext_count_clk_in_i(ext_count_clk_in_i),
        .cnt(cnt.clkgen)
    );

    assign cnt.run = q.run;
    assign cnt.clk_sel = q.clk_sel;
    assign cnt.div_code = q.div;

    // Bus qualifiers; one wait state keeps read data registered
    assign req = avs_read_i | avs_write_i;
    assign wr = avs_write_i & q.ack;
    assign rd_acc = avs_read_i & q.ack;
    assign wdata = avs_writedata_i[15:0];
    assign clr_cmd = wr && avs_address_i == PTE_IDX_CTL && avs_byteenable_i[0]
                     && wdata[PTE_CTL_CLR_BIT];
    assign cnt_wr = wr && avs_address_i == PTE_IDX_COUNT;
    assign flag_wr = wr && avs_address_i == PTE_IDX_FLAGS && avs_byteenable_i[0];

    // A tick already in flight when run drops must not count; gate by run
    assign count_en = cnt.tick & q.run;

    // Match detection on count enables only; fine mode drops compare A bit 0
    assign match_a = count_en && (q.fine ? (q.count[14:0] == q.cmp_a[15:1])
                                         : (q.count == q.cmp_a));
    assign match_b = count_en && (q.count == q.cmp_b);

    // Read mux; buffered compares read back the buffer, reserved bits zero
    always_comb begin
        rd_mux = 16'h0000;
        case (avs_address_i)
            PTE_IDX_CMP_A: rd_mux = q.buf_en ? q.buf_a : q.cmp_a;
            PTE_IDX_CMP_B: rd_mux = q.buf_en ? q.buf_b : q.cmp_b;
            PTE_IDX_COUNT: rd_mux = q.count;
            PTE_IDX_CTL: begin
                rd_mux[PTE_CTL_IDLE_BIT] = q.idle_lvl;
                rd_mux[PTE_CTL_FINE_BIT] = q.fine;
                rd_mux[PTE_CTL_BUF_EN_BIT] = q.buf_en;
                rd_mux[PTE_CTL_INV_BIT] = q.inv;
                rd_mux[PTE_CTL_CLK_SEL_BIT] = q.clk_sel;
                rd_mux[PTE_CTL_OUT_EN_BIT] = q.out_en;
                rd_mux[PTE_CTL_RUN_BIT] = q.run; // clear bit stays 0
            end
            PTE_IDX_DIV: rd_mux[3:0] = q.div;
            PTE_IDX_IRQ_EN: rd_mux[1:0] = q.irq_en;
            PTE_IDX_FLAGS: rd_mux[1:0] = q.flags;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Next state of the whole channel
    always_comb begin
        d = q;
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            d.rdata = rd_mux;
        end

        // Counting: B match resets, otherwise increment with wrap
        if (count_en) begin
            if (match_b) begin
                d.count = PTE_COUNT_RESET;
            end else begin
                d.count = q.count + 16'h0001;
            end
        end

        // Any counter reset reloads compares from buffers when enabled
        if (q.buf_en && (match_b || clr_cmd)) begin
            d.cmp_a = q.buf_a;
            d.cmp_b = q.buf_b;
        end
        if (clr_cmd) begin
            d.count = PTE_COUNT_RESET;
        end

        // Waveform level before polarity; half step defers the A edge
        if (match_a) begin
            if (q.fine && q.cmp_a[0]) begin
                d.pend_a = 1'b1;
            end else begin
                d.wave = 1'b1;
            end
        end
        if (cnt.half && q.pend_a) begin
            d.wave = 1'b1;
            d.pend_a = 1'b0;
        end
        if (match_b) begin
            d.wave = 1'b0;
            d.pend_a = 1'b0;
        end

        // Flags: hardware set wins over a same-cycle clear
        d.flags[PTE_IRQ_A_BIT] = (q.flags[PTE_IRQ_A_BIT]
            & ~(flag_wr & wdata[PTE_IRQ_A_BIT]))
            | (match_a & q.irq_en[PTE_IRQ_A_BIT]);
        d.flags[PTE_IRQ_B_BIT] = (q.flags[PTE_IRQ_B_BIT]
            & ~(flag_wr & wdata[PTE_IRQ_B_BIT]))
            | (match_b & q.irq_en[PTE_IRQ_B_BIT]);

        // Register writes; software wins over same-cycle hardware updates
        if (wr) begin
            case (avs_address_i)
                PTE_IDX_CMP_A: begin
                    if (q.buf_en) begin
                        d.buf_a = pte_merge(q.buf_a, wdata, avs_byteenable_i);
                    end else begin
                        d.cmp_a = pte_merge(q.cmp_a, wdata, avs_byteenable_i);
                    end
                end
                PTE_IDX_CMP_B: begin
                    if (q.buf_en) begin
                        d.buf_b = pte_merge(q.buf_b, wdata, avs_byteenable_i);
                    end else begin
                        d.cmp_b = pte_merge(q.cmp_b, wdata, avs_byteenable_i);
                    end
                end
                PTE_IDX_COUNT: d.count = pte_merge(q.count, wdata, avs_byteenable_i);
                PTE_IDX_CTL: begin
                    if (avs_byteenable_i[0]) begin
                        d.fine = wdata[PTE_CTL_FINE_BIT];
                        d.buf_en = wdata[PTE_CTL_BUF_EN_BIT];
                        d.inv = wdata[PTE_CTL_INV_BIT];
                        d.clk_sel = wdata[PTE_CTL_CLK_SEL_BIT];
                        d.out_en = wdata[PTE_CTL_OUT_EN_BIT];
                        d.run = wdata[PTE_CTL_RUN_BIT];
                    end
                    if (avs_byteenable_i[1]) begin
                        d.idle_lvl = wdata[PTE_CTL_IDLE_BIT];
                    end
                end
                PTE_IDX_DIV: begin
                    if (avs_byteenable_i[0]) begin
                        d.div = wdata[3:0];
                    end
                end
                PTE_IDX_IRQ_EN: begin
                    if (avs_byteenable_i[0]) begin
                        d.irq_en = wdata[1:0];
                    end
                end
                default: d.flags = d.flags; // Unmapped or flags: nothing stored
            endcase
        end

        // Disabled output parks the waveform at the idle level
        if (!d.out_en) begin
            d.wave = d.idle_lvl;
            d.pend_a = 1'b0;
        end
        d.out_p = d.wave ^ d.inv;
        d.irq = |(d.flags & d.irq_en);
    end

    // Whole state registered; reset gives stopped timer, zero compares
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.cmp_a <= PTE_CMP_RESET;
            q.cmp_b <= PTE_CMP_RESET;
            q.buf_a <= PTE_CMP_RESET;
            q.buf_b <= PTE_CMP_RESET;
            q.count <= PTE_COUNT_RESET;
            q.div <= PTE_DIV_RESET;
            q.irq_en <= PTE_IRQ_RESET;
            q.flags <= PTE_IRQ_RESET;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o = {16'h0000, q.rdata};
    assign wave_out_p_o = q.out_p;
    assign wave_out_n_o = ~q.out_p;
    assign irq_o = q.irq;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence seq_req_wait;
        req && !q.ack;
    endsequence

    sequence seq_answer;
        !avs_waitrequest_o;
    endsequence

    AST_BUS_ONE_WAIT: assert property (seq_req_wait |-> avs_waitrequest_o ##1 seq_answer)
        else $error("Bus answer not after one wait state");
    AST_FLAG_A_GATED: assert property ((!q.irq_en[0] && !q.flags[0]) |=> !q.flags[0])
        else $error("Flag A set while its enable is 0");
    AST_FLAG_A_SET: assert property ((match_a && q.irq_en[0]) |=> q.flags[0])
        else $error("Flag A not set on enabled match");
    AST_FLAG_B_SET: assert property ((match_b && q.irq_en[1]) |=> q.flags[1])
        else $error("Flag B not set on enabled match");
    AST_IRQ_LEVEL: assert property (irq_o == |(q.flags & q.irq_en))
        else $error("Interrupt line disagrees with flags and enables");
    AST_W1C_A: assert property ((flag_wr && wdata[0] && !match_a) |=> !q.flags[0])
        else $error("Write of 1 did not clear flag A");
    AST_W0_KEEP: assert property ((flag_wr && !wdata[1] && q.flags[1]) |=> q.flags[1])
        else $error("Write of 0 altered flag B");
    AST_B_RESET: assert property ((match_b && !cnt_wr) |=> q.count == 16'h0000)
        else $error("Counter not reset on compare B match");
    AST_A_COUNTS_ON: assert property ((match_a && !match_b && !cnt_wr && !clr_cmd)
        |=> q.count == $past(q.count) + 16'h0001)
        else $error("Compare A match disturbed counting");
    AST_STOP_HOLD: assert property ((!q.run && !cnt_wr && !clr_cmd) ##1 !cnt.tick
        |-> $stable(q.count))
        else $error("Stopped counter changed");
    AST_IDLE_OUT: assert property ((!q.out_en && !wr)
        |=> wave_out_p_o == ($past(q.idle_lvl) ^ $past(q.inv)))
        else $error("Disabled output not at idle level");
    AST_CLR_READS_0: assert property ((rd_acc && avs_address_i == PTE_IDX_CTL)
        |-> !avs_readdata_o[1])
        else $error("Clear command bit read back as 1");

    // Output edges and buffer reload follow the match by one edge
    sequence seq_b_live;
        match_b && q.out_en && !wr;
    endsequence

    AST_FLAG_B_GATED: assert property ((!q.irq_en[1] && !q.flags[1]) |=> !q.flags[1])
        else $error("Flag B set while its enable is 0");
    AST_CLR_ZERO: assert property (clr_cmd |=> q.count == 16'h0000)
        else $error("Clear command left counter nonzero");
    AST_CNT_LOAD: assert property ((cnt_wr && avs_byteenable_i[1:0] == 2'h3)
        |=> q.count == $past(wdata))
        else $error("Counter write not loaded");
    AST_BUF_LOAD: assert property ((q.buf_en && match_b && !wr)
        |=> (q.cmp_a == $past(q.buf_a)) && (q.cmp_b == $past(q.buf_b)))
        else $error("Buffers not loaded on compare B match");
    AST_WAVE_A: assert property ((match_a && !match_b && !q.fine && q.out_en && !wr)
        |=> wave_out_p_o != q.inv)
        else $error("Output not active after compare A match");
    AST_FINE_DEFER: assert property ((match_a && q.fine && q.cmp_a[0] && !match_b
        && q.out_en && !wr) |=> q.pend_a)
        else $error("Fine mode half step not deferred");
    AST_WAVE_B: assert property (seq_b_live |=> wave_out_p_o == q.inv)
        else $error("Output not inactive after compare B match");

endmodule
